// ### logic/rmi_pkg.sv
//----------------------------------------------------------------------
// Purpose: shared constants and carriers of the radio module interface
//----------------------------------------------------------------------
// Assumes: one core clock, synchronous active high reset
// Notes:   expander register offsets are pointer values on the i2c link
package rmi_pkg;

   //----------------------------------------------------------------
   // gpio expander on the i2c link
   //----------------------------------------------------------------
   localparam logic [6:0] EXP_I2C_ADDR   = 7'h20; // 7-bit device address
   localparam logic [7:0] EXP_REG_INPUT  = 8'h00; // pin levels, read only
   localparam logic [7:0] EXP_REG_OUTPUT = 8'h01; // output latch
   localparam logic [7:0] EXP_REG_CONFIG = 8'h03; // 1 = pin is an input
   localparam logic [7:0] EXP_OUT_RST    = 8'hff;
   localparam logic [7:0] EXP_OE_RST     = 8'h00; // all pins released
   localparam logic [7:0] EXP_OUT_MASK   = 8'h0f; // four drivable outputs
   localparam int         EXP_SPI_EN_BIT = 0;
   localparam logic [7:0] EXP_RD_PAD     = 8'h00; // unmapped pointer read
   localparam logic [1:0] STRAP_SETTLE   = 2'h3;  // cycles before strap latch

   //----------------------------------------------------------------
   // carriers
   //----------------------------------------------------------------
   typedef struct packed {
      logic sck;
      logic sel;  // wpan_select, low selects
      logic mosi;
   } rmi_spi_t;

   localparam rmi_spi_t SPI_IDLE = '{sck: 1'b0, sel: 1'b1, mosi: 1'b0};

   typedef struct packed {
      logic wifi_sdio;
      logic wifi_usb;
      logic bt_uart;
      logic bt_pcm;
      logic bt_usb;
   } rmi_route_t;

   localparam rmi_route_t ROUTE_RST = '{wifi_sdio: 1'b1, wifi_usb: 1'b0,
                                        bt_uart: 1'b1, bt_pcm: 1'b1,
                                        bt_usb: 1'b0};

   typedef enum logic [2:0] {
      I2C_IDLE = 3'b000,
      I2C_ADDR = 3'b001,
      I2C_PTR  = 3'b010,
      I2C_DATA = 3'b011,
      I2C_ACK  = 3'b100,
      I2C_TX   = 3'b101,
      I2C_RACK = 3'b110
   } rmi_i2c_state_t;

endpackage

// ### logic/rmi_sync.sv
//----------------------------------------------------------------------
// Purpose: three flop pin synchroniser with agreement filter
//----------------------------------------------------------------------
// Assumes: inputs asynchronous to core_clk
// Notes:   output follows once second and third stage agree
`timescale 1ns/1ps
module rmi_sync #(
   parameter int         W    = 1,
   parameter logic [W-1:0] INIT = '0
) (
   // clock and reset
   input  wire logic         core_clk,
   input  wire logic         rst,
   // pins and filtered levels
   input  wire logic [W-1:0] pin,
   output logic      [W-1:0] level_q
);
   logic [W-1:0] s1_q;
   logic [W-1:0] s2_q;
   logic [W-1:0] s3_q;
   logic [W-1:0] agree;

   // refuse an empty bus at elaboration
   if (W < 1)
   begin
      $error("rmi_sync width must be at least one");
   end

   // bits whose last two stages match
   assign agree = ~(s2_q ^ s3_q);

   // capture chain and filtered level
   always_ff @(posedge core_clk)
   begin
      if (rst)
      begin
         s1_q    <= INIT;
         s2_q    <= INIT;
         s3_q    <= INIT;
         level_q <= INIT;
      end
      else
      begin
         s1_q    <= pin;
         s2_q    <= s1_q;
         s3_q    <= s2_q;
         level_q <= (s2_q & agree) | (level_q & ~agree);
      end
   end
endmodule

// ### logic/rmi_ctrl.sv
//----------------------------------------------------------------------
// Purpose: host edge control of a wireless radio module
//----------------------------------------------------------------------
// Assumes: all connector and radio inputs asynchronous to core_clk
// Notes:   i2c link sampled by core_clk, scl well below core rate
//
// Functional notes
// RL1: wifi uses sdio by default, usb when the strap selects it
// RL2: with wifi on sdio, bluetooth runs on uart plus pcm audio
// RL3: with wifi on usb, bluetooth also runs on usb
// RL4: wifi power line high enables wifi part, low powers it down
// RL5: bluetooth power line high enables bluetooth part, low powers down
// RL6: module power line high enables module, low powers everything down
// RL7: spi buffer to connector enabled only while expander bit 0 is 1
// RL8: host reaches the expander at 7-bit i2c address 0x20
// RL9: spi route bit 0 isolates connector, header still reaches radio spi
// RL10: spi route bit 1 links radio spi to connector clock, select, data
// RL11: expander gives four output controls and one input signal
// RL12: bluetooth/wpan wake output signals wake-up to host
// RL13: wifi wake output signals wifi wake-up to host
// RL14: wpan interrupt reaches host through an open-drain driver
// RL15: host is spi master driving sck, mosi, select, reading miso
// RL16: host holds module power low 2 ms after supply is good (bench holds it low 96 ns)
// RL17: expander pins stay released after reset until host writes
// RL18: interface strap takes effect only on power cycle, latched
// RL19: disabled spi buffer releases connector miso, ignores its inputs
`timescale 1ns/1ps
module rmi_ctrl
   import rmi_pkg::*;
(
   // clock and reset
   input  wire logic       core_clk,
   input  wire logic       rst,
   // host power and configuration lines
   input  wire logic       module_power_on_n,
   input  wire logic       ble_wpan_power_on_n,
   input  wire logic       wifi_power_on_n,
   input  wire logic       usb_strap,
   // radio power controls
   output logic            chip_powerdown_n,
   output logic            wifi_indep_reset,
   output logic            ble_indep_reset,
   // interface routing
   output rmi_route_t      route,
   // wake and interrupt from radio
   input  wire logic       radio_ble_wake,
   input  wire logic       radio_wifi_wake,
   input  wire logic       radio_spi_int,
   // wake and interrupt toward host
   output logic            ble_wake_out_n,
   output logic            wifi_wake_out,
   output logic            wifi_wake_oe,
   output logic            wpan_int_out,
   output logic            wpan_int_oe,
   // spi at connector
   input  wire rmi_spi_t   conn_spi,
   output logic            conn_miso_out,
   output logic            conn_miso_oe,
   // spi at expansion header
   input  wire rmi_spi_t   hdr_spi,
   output logic            hdr_miso,
   // spi toward radio
   output rmi_spi_t        radio_spi,
   input  wire logic       radio_miso,
   // i2c link, sda open drain
   input  wire logic       i2c_scl,
   input  wire logic       i2c_sda_in,
   output logic            i2c_sda_out,
   output logic            i2c_sda_oe,
   // expander pins
   input  wire logic [7:0] exp_pin_in,
   output logic      [7:0] exp_pin_out,
   output logic      [7:0] exp_pin_oe
);
   //----------------------------------------------------------------
   // input synchronisers
   //----------------------------------------------------------------
   logic [3:0] pwr_s;
   logic [1:0] i2c_s;
   rmi_spi_t   conn_s;
   rmi_spi_t   hdr_s;
   logic [3:0] rad_s;
   logic [7:0] exp_s;

   rmi_sync #(.W(4), .INIT(4'h0)) u_pwr (
      .core_clk (core_clk),
      .rst      (rst),
      .pin      ({module_power_on_n, ble_wpan_power_on_n, wifi_power_on_n, usb_strap}),
      .level_q  (pwr_s)
   );
   rmi_sync #(.W(2), .INIT(2'h3)) u_i2c (
      .core_clk (core_clk),
      .rst      (rst),
      .pin      ({i2c_scl, i2c_sda_in}),
      .level_q  (i2c_s)
   );
   rmi_sync #(.W(3), .INIT(SPI_IDLE)) u_conn (
      .core_clk (core_clk),
      .rst      (rst),
      .pin      (conn_spi),
      .level_q  (conn_s)
   );
   rmi_sync #(.W(3), .INIT(SPI_IDLE)) u_hdr (
      .core_clk (core_clk),
      .rst      (rst),
      .pin      (hdr_spi),
      .level_q  (hdr_s)
   );
   rmi_sync #(.W(4), .INIT(4'h0)) u_rad (
      .core_clk (core_clk),
      .rst      (rst),
      .pin      ({radio_ble_wake, radio_wifi_wake, radio_spi_int, radio_miso}),
      .level_q  (rad_s)
   );
   rmi_sync #(.W(8), .INIT(8'h00)) u_exp (
      .core_clk (core_clk),
      .rst      (rst),
      .pin      (exp_pin_in),
      .level_q  (exp_s)
   );

   //----------------------------------------------------------------
   // power and routing decode
   //----------------------------------------------------------------
   logic       mod_on;
   logic       ble_on;
   logic       wifi_on;
   logic       strap;
   logic [1:0] settle_q;
   logic       strap_q;
   logic       latch_cfg;
   rmi_route_t route_d;

   assign mod_on    = pwr_s[3];                          // [RL6]
   assign ble_on    = mod_on & pwr_s[2];                 // [RL5]
   assign wifi_on   = mod_on & pwr_s[1];                 // [RL4]
   assign strap     = pwr_s[0];
   assign latch_cfg = (settle_q != STRAP_SETTLE) | ~mod_on; // [RL18]
   assign route_d   = '{wifi_sdio: ~strap_q, wifi_usb: strap_q,       // [RL1]
                        bt_uart: ~strap_q, bt_pcm: ~strap_q,          // [RL2]
                        bt_usb: strap_q};                             // [RL3]

   // strap capture while settling or module powered down
   always_ff @(posedge core_clk)
   begin
      if (rst)
      begin
         settle_q <= 2'h0;
         strap_q  <= 1'b0;
      end
      else
      begin
         if (settle_q != STRAP_SETTLE)
            settle_q <= settle_q + 2'h1;
         if (latch_cfg)
            strap_q <= strap;                            // [RL18]
      end
   end

   // registered power, routing, wake and interrupt outputs
   always_ff @(posedge core_clk)
   begin
      if (rst)
      begin
         chip_powerdown_n <= 1'b0;
         wifi_indep_reset <= 1'b0;
         ble_indep_reset  <= 1'b0;
         route            <= ROUTE_RST;
         ble_wake_out_n   <= 1'b1;
         wifi_wake_out    <= 1'b0;
         wifi_wake_oe     <= 1'b0;
         wpan_int_out     <= 1'b0;
         wpan_int_oe      <= 1'b0;
      end
      else
      begin
         chip_powerdown_n <= mod_on;                     // [RL6]
         wifi_indep_reset <= wifi_on;                    // [RL4]
         ble_indep_reset  <= ble_on;                     // [RL5]
         route            <= route_d;
         ble_wake_out_n   <= ~(rad_s[3] & ble_on);       // [RL12]
         wifi_wake_oe     <= rad_s[2] & wifi_on;         // [RL13]
         wpan_int_oe      <= rad_s[1] & ble_on;          // [RL14]
      end
   end

   //----------------------------------------------------------------
   // spi route buffer
   //----------------------------------------------------------------
   logic exp_out_q0;
   logic route_en;

   assign route_en = exp_pin_oe[EXP_SPI_EN_BIT] & exp_out_q0; // [RL7]

   // connector or header feeds the radio; miso released when off
   always_ff @(posedge core_clk)
   begin
      if (rst)
      begin
         radio_spi     <= SPI_IDLE;
         conn_miso_out <= 1'b0;
         conn_miso_oe  <= 1'b0;
         hdr_miso      <= 1'b0;
      end
      else
      begin
         radio_spi     <= route_en ? conn_s : hdr_s;     // [RL9] [RL10] [RL19]
         conn_miso_out <= rad_s[0];                      // [RL10]
         conn_miso_oe  <= route_en;                      // [RL19]
         hdr_miso      <= rad_s[0];                      // [RL9]
      end
   end

   //----------------------------------------------------------------
   // i2c gpio expander
   //----------------------------------------------------------------
   rmi_i2c_state_t st_q;
   logic           scl_p_q;
   logic           sda_p_q;
   logic [3:0]     cnt_q;
   logic [7:0]     sh_q;
   logic [7:0]     ptr_q;
   logic           rd_q;
   logic           got_ptr_q;
   logic           nack_q;
   logic [7:0]     out_q;
   logic           scl;
   logic           sda;
   logic           scl_rise;
   logic           scl_fall;
   logic           start_c;
   logic           stop_c;
   logic           full;
   logic [7:0]     rd_data;

   assign scl        = i2c_s[1];
   assign sda        = i2c_s[0];
   assign scl_rise   = scl & ~scl_p_q;
   assign scl_fall   = ~scl & scl_p_q;
   assign start_c    = scl & scl_p_q & sda_p_q & ~sda;
   assign stop_c     = scl & scl_p_q & ~sda_p_q & sda;
   assign full       = (cnt_q == 4'h8);
   assign exp_out_q0 = out_q[EXP_SPI_EN_BIT];
   assign rd_data    = (ptr_q == EXP_REG_INPUT)  ? exp_s :   // [RL11]
                       (ptr_q == EXP_REG_OUTPUT) ? out_q :
                       (ptr_q == EXP_REG_CONFIG) ? ~exp_pin_oe : EXP_RD_PAD;

   // line history
   always_ff @(posedge core_clk)
   begin
      if (rst)
      begin
         scl_p_q <= 1'b1;
         sda_p_q <= 1'b1;
      end
      else
      begin
         scl_p_q <= scl;
         sda_p_q <= sda;
      end
   end

   // bit engine: sample on rising scl, drive on falling scl
   always_ff @(posedge core_clk)
   begin
      if (rst)
      begin
         st_q        <= I2C_IDLE;
         cnt_q       <= 4'h0;
         sh_q        <= 8'h00;
         ptr_q       <= 8'h00;
         rd_q        <= 1'b0;
         got_ptr_q   <= 1'b0;
         nack_q      <= 1'b0;
         out_q       <= EXP_OUT_RST;
         exp_pin_oe  <= EXP_OE_RST;                      // [RL17]
         exp_pin_out <= EXP_OUT_RST;
         i2c_sda_out <= 1'b0;
         i2c_sda_oe  <= 1'b0;
      end
      else if (start_c)
      begin
         st_q       <= I2C_ADDR;
         cnt_q      <= 4'h0;
         got_ptr_q  <= 1'b0;
         i2c_sda_oe <= 1'b0;
      end
      else if (stop_c)
      begin
         st_q       <= I2C_IDLE;
         i2c_sda_oe <= 1'b0;
      end
      else
      begin
         exp_pin_out <= out_q;
         unique case (st_q)
            I2C_IDLE: ;
            I2C_ADDR, I2C_PTR, I2C_DATA:
            begin
               if (scl_rise && !full)
               begin
                  sh_q  <= {sh_q[6:0], sda};
                  cnt_q <= cnt_q + 4'h1;
               end
               else if (scl_fall && full)
               begin
                  cnt_q <= 4'h0;
                  st_q  <= I2C_ACK;
                  i2c_sda_oe <= 1'b1;
                  if (st_q == I2C_ADDR)
                  begin
                     rd_q <= sh_q[0];
                     if (sh_q[7:1] != EXP_I2C_ADDR)      // [RL8]
                     begin
                        st_q       <= I2C_IDLE;
                        i2c_sda_oe <= 1'b0;
                     end
                  end
                  else if (st_q == I2C_PTR)
                  begin
                     ptr_q     <= sh_q;
                     got_ptr_q <= 1'b1;
                  end
                  else if (ptr_q == EXP_REG_OUTPUT)
                     out_q <= sh_q;                      // [RL11]
                  else if (ptr_q == EXP_REG_CONFIG)
                     exp_pin_oe <= ~sh_q & EXP_OUT_MASK; // [RL11] [RL17]
               end
            end
            I2C_ACK:
            begin
               if (scl_fall)
               begin
                  i2c_sda_oe <= 1'b0;
                  if (rd_q)
                  begin
                     st_q       <= I2C_TX;
                     sh_q       <= {rd_data[6:0], 1'b0};
                     cnt_q      <= 4'h1;
                     i2c_sda_oe <= ~rd_data[7];
                  end
                  else
                     st_q <= got_ptr_q ? I2C_DATA : I2C_PTR;
               end
            end
            I2C_TX:
            begin
               if (scl_fall)
               begin
                  if (full)
                  begin
                     st_q       <= I2C_RACK;
                     i2c_sda_oe <= 1'b0;
                  end
                  else
                  begin
                     i2c_sda_oe <= ~sh_q[7];
                     sh_q       <= {sh_q[6:0], 1'b0};
                     cnt_q      <= cnt_q + 4'h1;
                  end
               end
            end
            I2C_RACK:
            begin
               if (scl_rise)
                  nack_q <= sda;
               else if (scl_fall)
               begin
                  // master ack: next byte goes out at once, its msb now
                  st_q       <= nack_q ? I2C_IDLE : I2C_TX;
                  sh_q       <= {rd_data[6:0], 1'b0};
                  cnt_q      <= 4'h1;
                  i2c_sda_oe <= ~nack_q & ~rd_data[7];
               end
            end
            default: st_q <= I2C_IDLE;
         endcase
      end
   end
endmodule

// ### test/rmi_ctrl_monitor.sv
// Purpose: port checker for rmi_ctrl
// Assumes: pin latency at most eight core cycles
// Notes:   bound to every rmi_ctrl instance
`timescale 1ns/1ps
module rmi_ctrl_monitor
   import rmi_pkg::*;
(
   // clock and reset
   input wire logic       core_clk,
   input wire logic       rst,
   // power and routing
   input wire logic       module_power_on_n,
   input wire logic       ble_wpan_power_on_n,
   input wire logic       wifi_power_on_n,
   input wire logic       chip_powerdown_n,
   input wire logic       wifi_indep_reset,
   input wire logic       ble_indep_reset,
   input wire rmi_route_t route,
   // wake and interrupt
   input wire logic       ble_wake_out_n,
   input wire logic       wpan_int_oe,
   // spi and expander
   input wire rmi_spi_t   conn_spi,
   input wire rmi_spi_t   hdr_spi,
   input wire rmi_spi_t   radio_spi,
   input wire logic       radio_miso,
   input wire logic       conn_miso_out,
   input wire logic       conn_miso_oe,
   input wire logic [7:0] exp_pin_out,
   input wire logic [7:0] exp_pin_oe
);
   //--------------------
   // checks
   //--------------------
   wire logic route_en;
   // connector buffer enable as the expander drives it
   assign route_en = exp_pin_oe[0] & exp_pin_out[0];
   default clocking @(posedge core_clk); endclocking
   default disable iff (rst);
   module_down_a: assert property (
      !module_power_on_n [*8] |-> !chip_powerdown_n && !wifi_indep_reset)
      else $error("module still up");
   wifi_on_a: assert property (
      (module_power_on_n && wifi_power_on_n) [*8] |-> wifi_indep_reset)
      else $error("wifi not up");
   ble_off_a: assert property (
      !ble_wpan_power_on_n [*8] |-> !ble_indep_reset && ble_wake_out_n && !wpan_int_oe)
      else $error("ble still up");
   route_pair_a: assert property (
      route.bt_usb == route.wifi_usb && route.bt_uart == route.wifi_sdio
      && route.bt_pcm == route.bt_uart && route.wifi_sdio != route.wifi_usb)
      else $error("route mix");
   strap_hold_a: assert property (chip_powerdown_n [*4] |-> $stable(route))
      else $error("route moved while on");
   spi_conn_a: assert property (
      (route_en && $stable(conn_spi)) [*8] |-> radio_spi == conn_spi)
      else $error("connector spi not passed");
   spi_hdr_a: assert property (
      (!route_en && $stable(hdr_spi)) [*8] |-> radio_spi == hdr_spi)
      else $error("header spi not passed");
   miso_off_a: assert property (!route_en [*2] |-> !conn_miso_oe)
      else $error("miso driven while off");
   miso_on_a: assert property (
      (route_en && $stable(radio_miso)) [*8] |-> conn_miso_oe && conn_miso_out == radio_miso)
      else $error("miso not passed");
   oe_release_a: assert property ($past(rst) |-> exp_pin_oe == EXP_OE_RST)
      else $error("expander pins driven");
   oe_mask_a: assert property (exp_pin_oe[7:4] == 4'h0)
      else $error("input pin driven");
   cover property (route.wifi_usb);
   cover property (conn_miso_oe && conn_miso_out);
   cover property (!ble_wake_out_n && wpan_int_oe);
endmodule
bind rmi_ctrl rmi_ctrl_monitor mon_u (.*);

// ### test/rmi_host_model.sv
// Purpose: host processor model, i2c and spi master
// Assumes: scl near 4.5 MHz, sck 160 ns period
// Notes:   sda has a pull-up, sck stands low between frames
`timescale 1ns/1ps
module rmi_host_model
   import rmi_pkg::*;
(
   // clock
   input wire logic core_clk,
   // i2c link
   input wire logic dut_sda_oe,
   output logic     i2c_scl,
   output logic     i2c_sda_in,
   // spi master at connector
   output rmi_spi_t conn_spi
);
   //--------------------
   // bus tasks
   //--------------------
   logic sda_oe_h = 1'b0;
   // open drain line, pulled up when nobody pulls low
   assign i2c_sda_in = !(sda_oe_h || dut_sda_oe);
   initial
   begin
      i2c_scl = 1'b1;
      conn_spi = SPI_IDLE;
   end
   task tick(input int n);
      repeat (n) @(posedge core_clk);
      #1;
   endtask
   // eight bits then a released ninth bit
   task i2c_byte(input logic [7:0] b, output logic [7:0] r, output logic ack);
      for (int i = 8; i >= 0; i--)
      begin
         sda_oe_h = (i > 0) ? ~b[i-1] : 1'b0;
         tick(10);
         i2c_scl = 1'b1;
         tick(5);
         if (i > 0)
            r[i-1] = i2c_sda_in;
         else
            ack = !i2c_sda_in;
         tick(5);
         i2c_scl = 1'b0;
         tick(2);
      end
   endtask
   // start, address byte, n more bytes (two at most), stop
   task i2c_xfer(input logic [7:0] a, p, d, input int n,
                 output logic [7:0] r, output logic [2:0] ak);
      logic [7:0] q;
      ak = 3'h0;
      r = 8'h00;
      sda_oe_h = 1'b1;
      tick(10);
      i2c_scl = 1'b0;
      tick(2);
      i2c_byte(a, q, ak[2]);
      if (n > 0)
         i2c_byte(p, r, ak[1]);
      if (n > 1)
         i2c_byte(d, q, ak[0]);
      sda_oe_h = 1'b1;
      tick(10);
      i2c_scl = 1'b1;
      tick(10);
      sda_oe_h = 1'b0;
      tick(20);
   endtask
   // one spi byte, msb first, sample on rise
   task spi_byte(input logic [7:0] tx);
      conn_spi.sel = 1'b0;
      for (int i = 7; i >= 0; i--)
      begin
         conn_spi.mosi = tx[i];
         tick(8);
         conn_spi.sck = 1'b1;
         tick(8);
         conn_spi.sck = 1'b0;
      end
      tick(8);
      conn_spi.sel = 1'b1;
      conn_spi.mosi = ~conn_spi.mosi; // a released line keeps no stale level
   endtask
endmodule

// ### test/rmi_ctrl_tb.sv
// Purpose: self-checking bench for rmi_ctrl
// Assumes: host model drives i2c and connector spi
// Notes:   waits of 8 cycles cover the pin synchronisers
`timescale 1ns/1ps
module rmi_ctrl_tb
   import rmi_pkg::*;
;
   logic       core_clk = 1'b0;
   logic       rst = 1'b1;
   logic       module_power_on_n = 1'b0;
   logic       ble_wpan_power_on_n = 1'b1;
   logic       wifi_power_on_n = 1'b1;
   logic       usb_strap = 1'b0;
   logic       radio_ble_wake = 1'b0;
   logic       radio_wifi_wake = 1'b0;
   logic       radio_spi_int = 1'b0;
   logic       radio_miso = 1'b0;
   rmi_spi_t   hdr_spi = SPI_IDLE;
   logic [7:0] exp_pin_in = 8'h10;
   logic       i2c_scl, i2c_sda_in, i2c_sda_oe, sck_q;
   logic       wifi_wake_out, wpan_int_out, i2c_sda_out;
   logic       chip_powerdown_n, wifi_indep_reset, ble_indep_reset, ble_wake_out_n;
   logic       wifi_wake_oe, wpan_int_oe, conn_miso_out, conn_miso_oe, hdr_miso;
   rmi_spi_t   conn_spi, radio_spi;
   rmi_route_t route;
   logic [7:0] exp_pin_out, exp_pin_oe, rd, cap;
   logic [2:0] ak;
   int         bad_count = 0;
   int         n_compared = 0;
   int         sck_count = 0;

   //--------------------
   // design and host
   //--------------------
   always #5 core_clk = ~core_clk;
   rmi_ctrl dut_u (.core_clk, .rst, .module_power_on_n, .ble_wpan_power_on_n,
      .wifi_power_on_n, .usb_strap, .chip_powerdown_n, .wifi_indep_reset,
      .ble_indep_reset, .route, .radio_ble_wake, .radio_wifi_wake, .radio_spi_int,
      .ble_wake_out_n, .wifi_wake_out, .wifi_wake_oe, .wpan_int_out, .wpan_int_oe,
      .conn_spi, .conn_miso_out, .conn_miso_oe, .hdr_spi, .hdr_miso, .radio_spi,
      .radio_miso, .i2c_scl, .i2c_sda_in, .i2c_sda_out, .i2c_sda_oe, .exp_pin_in,
      .exp_pin_out, .exp_pin_oe);
   rmi_host_model host_u (.core_clk, .dut_sda_oe(i2c_sda_oe), .i2c_scl, .i2c_sda_in,
      .conn_spi);
   // radio side: count sck rises and shift in mosi
   always @(posedge core_clk)
   begin
      sck_q <= radio_spi.sck;
      if (radio_spi.sck && !sck_q)
      begin
         sck_count <= sck_count + 1;
         cap <= {cap[6:0], radio_spi.mosi};
      end
   end

   //--------------------
   // tasks
   //--------------------
   task tick(input int n);
      repeat (n) @(posedge core_clk);
      #1;
   endtask
   task chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
      n_compared++;
      if (seen !== exp)
      begin
         bad_count++;
         $display("FAIL %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task summarize();
      $display("compared %0d mismatched %0d", n_compared, bad_count);
      if (bad_count == 0 && n_compared > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   task pwr(input logic on);
      module_power_on_n = on;
      tick(8);
   endtask
   task wr(input logic [7:0] p, input logic [7:0] d);
      host_u.i2c_xfer(8'h40, p, d, 2, rd, ak);
      chk("write acks", {5'h0, ak}, 8'h07);
   endtask
   task rdback(input logic [7:0] p, input logic [7:0] exp);
      host_u.i2c_xfer(8'h40, p, 8'h00, 1, rd, ak);
      host_u.i2c_xfer(8'h41, 8'hff, 8'h00, 1, rd, ak);
      chk("read data", rd, exp);
   endtask

   //--------------------
   // sequence
   //--------------------
   initial
   begin
      tick(2);
      rst = 1'b0;
      tick(8); // module power held low past the settle span
      chk("oe at reset", exp_pin_oe, EXP_OE_RST);
      chk("module down", {6'h0, chip_powerdown_n, wifi_indep_reset}, 8'h00);
      pwr(1'b1);
      chk("all on", {5'h0, chip_powerdown_n, wifi_indep_reset, ble_indep_reset},
          8'h07);
      chk("route sdio", {3'h0, route}, {3'h0, ROUTE_RST});
      wifi_power_on_n = 1'b0;
      tick(8);
      chk("wifi off", {6'h0, wifi_indep_reset, ble_indep_reset}, 8'h01);
      wifi_power_on_n = 1'b1;
      ble_wpan_power_on_n = 1'b0;
      radio_ble_wake = 1'b1;
      radio_wifi_wake = 1'b1;
      radio_spi_int = 1'b1;
      tick(8);
      chk("ble off", {6'h0, wifi_indep_reset, ble_indep_reset}, 8'h02);
      chk("wake gated", {5'h0, ble_wake_out_n, wifi_wake_oe, wpan_int_oe}, 8'h06);
      ble_wpan_power_on_n = 1'b1;
      tick(8);
      chk("wake on", {5'h0, ble_wake_out_n, wifi_wake_oe, wpan_int_oe}, 8'h03);
      chk("open drain low", {5'h0, wifi_wake_out, wpan_int_out, i2c_sda_out}, 8'h00);
      radio_ble_wake = 1'b0;
      radio_wifi_wake = 1'b0;
      radio_spi_int = 1'b0;
      usb_strap = 1'b1;
      tick(8);
      chk("strap held", {3'h0, route}, {3'h0, ROUTE_RST});
      pwr(1'b0);
      pwr(1'b1);
      chk("route usb", {3'h0, route}, 8'h09);
      usb_strap = 1'b0;
      pwr(1'b0);
      pwr(1'b1);
      chk("route back", {3'h0, route}, {3'h0, ROUTE_RST});
      host_u.spi_byte(8'ha5);
      chk("sck while off", sck_count[7:0], 8'h00);
      chk("miso released", {7'h0, conn_miso_oe}, 8'h00);
      hdr_spi.sel = 1'b0;
      tick(8);
      chk("header select", {7'h0, radio_spi.sel}, 8'h00);
      hdr_spi.sel = 1'b1;
      host_u.i2c_xfer(8'h42, 8'h00, 8'h00, 0, rd, ak);
      chk("foreign address", {5'h0, ak}, 8'h00);
      wr(EXP_REG_CONFIG, 8'h00);
      chk("drivable pins", exp_pin_oe, 8'h0f);
      rdback(EXP_REG_CONFIG, 8'hf0);
      rdback(EXP_REG_INPUT, 8'h10);
      wr(EXP_REG_CONFIG, 8'hfe);
      chk("bit0 drives", exp_pin_oe, 8'h01);
      radio_miso = 1'b1;
      host_u.spi_byte(8'h3c);
      chk("sck count", sck_count[7:0], 8'h08);
      chk("radio mosi", cap, 8'h3c);
      chk("connector miso", {6'h0, conn_miso_oe, conn_miso_out}, 8'h03);
      chk("header miso", {7'h0, hdr_miso}, 8'h01);
      wr(EXP_REG_OUTPUT, 8'h0e);
      tick(2);
      chk("miso off", {6'h0, exp_pin_out[0], conn_miso_oe}, 8'h00);
      chk("latch pins", exp_pin_out, 8'h0e);
      rdback(EXP_REG_OUTPUT, 8'h0e);
      rdback(8'h02, EXP_RD_PAD);
      summarize();
   end
   // watchdog against a hung handshake
   initial
   begin
      #400us;
      bad_count++;
      summarize();
   end
endmodule
